// ### core/fssr_pkg.sv
// Shared constants for the security-page, unique-ID and soft-reset command core.
// Assumes a 100 MHz system clock and a host-driven serial clock that runs only inside frames.
package fssr_pkg;

	// ************************************************************
	// Opcodes
	// ************************************************************
	localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
	localparam logic [7:0] OP_RESET_ENABLE = 8'h66;
	localparam logic [7:0] OP_RESET = 8'h99;
	localparam logic [7:0] OP_UID_READ = 8'h4B;
	localparam logic [7:0] OP_SEC_ERASE = 8'h44;
	localparam logic [7:0] OP_SEC_PROGRAM = 8'h42;
	localparam logic [7:0] OP_SEC_READ = 8'h48;

	// ************************************************************
	// Frame bit positions
	// ************************************************************
	localparam int BITCNT_W = 12;
	localparam logic [11:0] BITS_OPCODE = 12'h008;
	localparam logic [11:0] BITS_ADDR_END = 12'h020;
	localparam logic [11:0] BITS_DATA_START = 12'h028;
	localparam logic [11:0] BITS_TOP = 12'hFFF;
	localparam logic [11:0] BITS_REWIND = 12'h800;

	// ************************************************************
	// Address fields
	// ************************************************************
	localparam int ADDR_TOP_HI = 23;
	localparam int ADDR_TOP_LO = 16;
	localparam int ADDR_PAGE_HI = 15;
	localparam int ADDR_PAGE_LO = 12;
	localparam int ADDR_ZERO_HI = 11;
	localparam int ADDR_ZERO_LO = 8;
	localparam logic [3:0] PAGE_FIRST = 4'h1;
	localparam logic [3:0] PAGE_LAST = 4'h3;
	localparam int ARRAY_AW = 10;
	localparam int PAGE_AW = 8;
	localparam logic [8:0] PAGE_BYTES = 9'h100;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;

	// ************************************************************
	// Status byte one
	// ************************************************************
	localparam int STATUS_BUSY_BIT = 0;
	localparam int STATUS_WEL_BIT = 1;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int CLK_FREQ_MHZ = 100;
	localparam int RESET_TIME_US = 30;
	localparam int RESET_CNT_W = 12;
	localparam logic [11:0] RESET_CYCLES = 12'(RESET_TIME_US * CLK_FREQ_MHZ);

	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ERASE = 3'b001,
		ST_PROG_RD = 3'b010,
		ST_PROG_WR = 3'b011,
		ST_SETTLE = 3'b100
	} fssr_state_t;

endpackage

// ### core/fssr_ram.sv
// Simple dual-clock memory: one write port and one registered read port.
// Assumes each port's address and data are stable around its own clock edge.
`timescale 1ns/10ps
`default_nettype none
module fssr_ram #(
	parameter int WIDTH = 8,
	parameter int AW = 8
) (
	// Write port
	input wire logic wr_clk,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	// Read port
	input wire logic rd_clk,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [0:(1<<AW)-1];

	if (WIDTH < 1 || AW < 1 || AW > 16) begin : g_chk
		$error("fssr_ram: unsupported WIDTH or AW");
	end

	always_ff @(posedge wr_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	always_ff @(posedge rd_clk) begin
		rd_data <= mem[rd_addr];
	end
endmodule
`default_nettype wire

// ### core/fssr_core.sv
// Security page erase/program/read, unique ID read and two-step soft reset.
// Assumes the host stops sclk while cs_n is high; frame words are read by clk only then.
// Behaviour
// RULE_01: Protection bit changes refused while wp low
// RULE_02: Soft reset aborts work, clears volatile state
// RULE_03: Reset only when 66h directly precedes 99h
// RULE_04: Any other command drops reset-enabled state
// RULE_05: Reject all commands for 30 us after reset
// RULE_06: Host checks busy and suspends before reset
// RULE_07: Unique ID: opcode, four dummies, 64 bits
// RULE_08: Erase needs latch set; starts at cs rise
// RULE_09: Erase ignores low address byte
// RULE_10: Erase aborts unless cs rises after A0
// RULE_11: Busy reported during erase, cleared after
// RULE_12: Aborted or protected erase clears write latch
// RULE_13: Lock bit set blocks page erase forever
// RULE_14: Page address: top zero, page 1-3, zero
// RULE_15: Program needs latch, opcode, address, then data
// RULE_16: Program data staged through internal page buffer
// RULE_17: Read: opcode, address, dummy, then data
// RULE_18: Sequential read wraps top to zero seamlessly; code carries past byte FF into the next page
// RULE_19: Cs rise ends read, output released
// RULE_20: Write enable sets latch on byte boundary
// RULE_21: Status bit one latch, bit zero busy
// RULE_22: Program needs data byte, unlocked page, boundary
// RULE_23: Finished erase or program clears latch, ready
`timescale 1ns/10ps
`default_nettype none
module fssr_core #(
	parameter logic [63:0] UID_VALUE = 64'h0123_4567_89AB_CDEF, // Arbitrary value
	parameter int SETTLE_CYCLES = 1000
) (
	// System
	input wire logic clk,
	input wire logic reset,
	// Serial link
	input wire logic sclk,
	input wire logic cs_n,
	input wire logic si,
	output logic so_out,
	output logic so_oe,
	// Write protect pin
	input wire logic wp_n,
	// Lock bit update
	input wire logic lock_write_strobe,
	input wire logic [2:0] lock_write_value,
	// Suspend and volatile settings
	input wire logic erase_suspend_set,
	input wire logic program_suspend_set,
	input wire logic suspend_clear,
	input wire logic mode_load,
	input wire logic [7:0] mode_value,
	input wire logic [2:0] wrap_value,
	// Status
	output logic write_enable_latch,
	output logic ready_busy_flag,
	output logic erase_suspended_flag,
	output logic program_suspended_flag,
	output logic page1_lock_bit,
	output logic page2_lock_bit,
	output logic page3_lock_bit,
	output logic [7:0] status_byte1,
	output logic [7:0] continuous_read_mode_byte,
	output logic [2:0] wrap_length_bits
);

	if (SETTLE_CYCLES < 1 || SETTLE_CYCLES > 65535) begin : g_chk
		$error("fssr_core: SETTLE_CYCLES out of range");
	end

	// ************************************************************
	// Functions
	// ************************************************************
	function automatic logic page_is_locked(input logic [1:0] page, input logic [2:0] locks);
		logic hit;
		hit = 1'b0;
		if (page != 2'b00) begin
			hit = locks[page - 2'b01];
		end
		return hit;
	endfunction

	function automatic logic [7:0] uid_byte(input logic [2:0] idx);
		logic [5:0] sh;
		logic [63:0] v;
		sh = {idx, 3'b000};
		v = UID_VALUE << sh;
		return v[63:56];
	endfunction

	// ************************************************************
	// Link domain: frame capture
	// ************************************************************
	logic frame_rst;
	logic frame_live_reg;
	logic frame_tog_reg;
	logic [11:0] bit_cnt_reg;
	logic [11:0] cnt_next;
	logic [31:0] shift_reg;
	logic [31:0] shift_next;
	logic [7:0] opcode_reg;
	logic [23:0] addr_reg;
	logic [8:0] data_cnt_reg;
	logic [9:0] read_ptr_reg;
	logic [7:0] out_byte_reg;
	logic [2:0] out_idx_reg;
	logic busy_l1_reg;
	logic busy_l2_reg;
	logic byte_done;
	logic buf_wr_en;
	logic [7:0] arr_rd_data;
	logic read_cmd;
	logic reset_busy;

	assign frame_rst = reset | cs_n; // RULE_19
	assign shift_next = {shift_reg[30:0], si};
	assign byte_done = cnt_next[2:0] == 3'h0;
	assign read_cmd = opcode_reg == fssr_pkg::OP_SEC_READ || opcode_reg == fssr_pkg::OP_UID_READ;

	always_comb begin
		if (!frame_live_reg) begin
			cnt_next = 12'h001;
		end else if (bit_cnt_reg == fssr_pkg::BITS_TOP) begin
			cnt_next = fssr_pkg::BITS_REWIND;
		end else begin
			cnt_next = bit_cnt_reg + 12'h001;
		end
	end

	always_ff @(posedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			frame_live_reg <= 1'b0;
		end else begin
			frame_live_reg <= 1'b1;
		end
	end

	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			frame_tog_reg <= 1'b0;
			bit_cnt_reg <= 12'h000;
			shift_reg <= 32'h0000_0000;
			opcode_reg <= 8'h00;
			addr_reg <= 24'h00_0000;
		end else begin
			if (!frame_live_reg) begin
				frame_tog_reg <= ~frame_tog_reg;
			end
			bit_cnt_reg <= cnt_next;
			shift_reg <= shift_next;
			if (cnt_next == fssr_pkg::BITS_OPCODE) begin
				opcode_reg <= shift_next[7:0];
			end
			if (cnt_next == fssr_pkg::BITS_ADDR_END) begin
				addr_reg <= shift_next[23:0];
			end
		end
	end

	// Program data bytes into the page buffer, wrapping within the page
	assign buf_wr_en = opcode_reg == fssr_pkg::OP_SEC_PROGRAM && byte_done
		&& cnt_next >= fssr_pkg::BITS_DATA_START; // RULE_16

	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			data_cnt_reg <= 9'h000;
		end else if (!frame_live_reg) begin
			data_cnt_reg <= 9'h000;
		end else if (buf_wr_en && data_cnt_reg != fssr_pkg::PAGE_BYTES) begin
			data_cnt_reg <= data_cnt_reg + 9'h001;
		end
	end

	// Read pointer and output byte
	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			read_ptr_reg <= 10'h000;
			out_byte_reg <= 8'h00;
			out_idx_reg <= 3'h0;
		end else if (cnt_next == fssr_pkg::BITS_ADDR_END) begin
			read_ptr_reg <= {shift_next[13:12], shift_next[7:0]}; // RULE_09
			out_idx_reg <= 3'h0;
		end else if (byte_done && cnt_next >= fssr_pkg::BITS_DATA_START) begin
			if (opcode_reg == fssr_pkg::OP_SEC_READ) begin
				out_byte_reg <= arr_rd_data; // RULE_17
				read_ptr_reg <= read_ptr_reg + 10'h001; // RULE_18
			end else begin
				out_byte_reg <= uid_byte(out_idx_reg); // RULE_07
				out_idx_reg <= out_idx_reg + 3'h1;
			end
		end
	end

	// Reset window seen from the link side
	always_ff @(posedge sclk or posedge reset) begin
		if (reset) begin
			busy_l1_reg <= 1'b0;
			busy_l2_reg <= 1'b0;
		end else begin
			busy_l1_reg <= reset_busy;
			busy_l2_reg <= busy_l1_reg;
		end
	end

	// Output shifts on falling edges; cs rise releases it at once
	always_ff @(negedge sclk or posedge frame_rst) begin
		if (frame_rst) begin
			so_oe <= 1'b0; // RULE_19
			so_out <= 1'b0;
		end else if (frame_live_reg && read_cmd && !busy_l2_reg
				&& bit_cnt_reg >= fssr_pkg::BITS_DATA_START) begin
			so_oe <= 1'b1; // RULE_07
			so_out <= out_byte_reg[3'h7 - bit_cnt_reg[2:0]];
		end else begin
			so_oe <= 1'b0; // RULE_05
			so_out <= 1'b0;
		end
	end

	// ************************************************************
	// System domain: synchronisers
	// ************************************************************
	logic cs_s1_reg;
	logic cs_s2_reg;
	logic cs_s3_reg;
	logic wp_s1_reg;
	logic wp_s2_reg;
	logic seen_tog_reg;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_s3_reg <= 1'b1;
			wp_s1_reg <= 1'b0;
			wp_s2_reg <= 1'b0;
		end else begin
			cs_s1_reg <= cs_n;
			cs_s2_reg <= cs_s1_reg;
			cs_s3_reg <= cs_s2_reg;
			wp_s1_reg <= wp_n;
			wp_s2_reg <= wp_s1_reg;
		end
	end

	// ************************************************************
	// System domain: frame decode
	// ************************************************************
	// Frame words are stable here: sclk has stopped once cs_n is high
	logic frame_end;
	logic full_op;
	logic on_byte;
	logic [3:0] page_sel;
	logic page_ok;
	logic locked;
	logic op_busy;
	logic accept;
	logic write_cmd;
	logic do_soft_reset;
	logic erase_start;
	logic erase_abort;
	logic prog_start;
	logic prog_abort;
	logic reset_enabled_reg;
	logic [11:0] reset_cnt_reg;
	logic [2:0] lock_reg;
	fssr_pkg::fssr_state_t state_reg;
	logic [8:0] op_cnt_reg;
	logic [8:0] op_len_reg;
	logic [1:0] op_page_reg;
	logic [7:0] op_off_reg;
	logic [15:0] settle_cnt_reg;
	logic settle_done;

	assign frame_end = cs_s2_reg && !cs_s3_reg && frame_tog_reg != seen_tog_reg;
	assign full_op = bit_cnt_reg >= fssr_pkg::BITS_OPCODE;
	assign on_byte = bit_cnt_reg[2:0] == 3'h0;
	assign page_sel = addr_reg[fssr_pkg::ADDR_PAGE_HI:fssr_pkg::ADDR_PAGE_LO];
	assign page_ok = addr_reg[fssr_pkg::ADDR_TOP_HI:fssr_pkg::ADDR_TOP_LO] == 8'h00
		&& addr_reg[fssr_pkg::ADDR_ZERO_HI:fssr_pkg::ADDR_ZERO_LO] == 4'h0
		&& page_sel >= fssr_pkg::PAGE_FIRST && page_sel <= fssr_pkg::PAGE_LAST; // RULE_14
	assign locked = page_is_locked(page_sel[1:0], lock_reg); // RULE_13
	assign op_busy = state_reg != fssr_pkg::ST_IDLE;
	assign reset_busy = reset_cnt_reg != 12'h000;
	assign accept = frame_end && !reset_busy && full_op; // RULE_05
	assign write_cmd = accept && write_enable_latch && !op_busy;
	assign do_soft_reset = accept && opcode_reg == fssr_pkg::OP_RESET && reset_enabled_reg; // RULE_03
	assign erase_start = write_cmd && opcode_reg == fssr_pkg::OP_SEC_ERASE
		&& bit_cnt_reg == fssr_pkg::BITS_ADDR_END && page_ok && !locked; // RULE_08 RULE_10
	assign erase_abort = write_cmd && opcode_reg == fssr_pkg::OP_SEC_ERASE && !erase_start;
	assign prog_start = write_cmd && opcode_reg == fssr_pkg::OP_SEC_PROGRAM && on_byte
		&& bit_cnt_reg >= fssr_pkg::BITS_DATA_START && page_ok && !locked; // RULE_15 RULE_22
	assign prog_abort = write_cmd && opcode_reg == fssr_pkg::OP_SEC_PROGRAM && !prog_start;
	assign settle_done = state_reg == fssr_pkg::ST_SETTLE && settle_cnt_reg == 16'h0000;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			seen_tog_reg <= 1'b0;
		end else if (cs_s2_reg && !cs_s3_reg) begin
			seen_tog_reg <= frame_tog_reg;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reset_enabled_reg <= 1'b0;
		end else if (accept) begin
			reset_enabled_reg <= opcode_reg == fssr_pkg::OP_RESET_ENABLE; // RULE_04
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			reset_cnt_reg <= 12'h000;
		end else if (do_soft_reset) begin
			reset_cnt_reg <= fssr_pkg::RESET_CYCLES; // RULE_05
		end else if (reset_busy) begin
			reset_cnt_reg <= reset_cnt_reg - 12'h001;
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			write_enable_latch <= 1'b0;
		end else if (do_soft_reset) begin
			write_enable_latch <= 1'b0; // RULE_02
		end else if (settle_done) begin
			write_enable_latch <= 1'b0; // RULE_23
		end else if (erase_abort || prog_abort) begin
			write_enable_latch <= 1'b0; // RULE_12
		end else if (accept && on_byte && opcode_reg == fssr_pkg::OP_WRITE_ENABLE) begin
			write_enable_latch <= 1'b1; // RULE_20
		end else if (accept && on_byte && opcode_reg == fssr_pkg::OP_WRITE_DISABLE) begin
			write_enable_latch <= 1'b0;
		end
	end

	// Lock bits only ever set; power reset stands in for their nonvolatile state
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lock_reg <= 3'b000;
		end else if (lock_write_strobe && wp_s2_reg) begin
			lock_reg <= lock_reg | lock_write_value; // RULE_01
		end
	end

	// Suspend flags: a set in the clearing cycle wins
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			erase_suspended_flag <= 1'b0;
			program_suspended_flag <= 1'b0;
		end else if (do_soft_reset) begin
			erase_suspended_flag <= 1'b0; // RULE_02
			program_suspended_flag <= 1'b0;
		end else begin
			erase_suspended_flag <= erase_suspend_set | (erase_suspended_flag & ~suspend_clear);
			program_suspended_flag <= program_suspend_set
				| (program_suspended_flag & ~suspend_clear);
		end
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			continuous_read_mode_byte <= 8'h00;
			wrap_length_bits <= 3'h0;
		end else if (do_soft_reset) begin
			continuous_read_mode_byte <= 8'h00; // RULE_02
			wrap_length_bits <= 3'h0;
		end else if (mode_load) begin
			continuous_read_mode_byte <= mode_value;
			wrap_length_bits <= wrap_value;
		end
	end

	// ************************************************************
	// System domain: self-timed erase and program
	// ************************************************************
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= fssr_pkg::ST_IDLE;
			op_cnt_reg <= 9'h000;
			op_len_reg <= 9'h000;
			op_page_reg <= 2'b00;
			op_off_reg <= 8'h00;
			settle_cnt_reg <= 16'h0000;
		end else if (do_soft_reset) begin
			state_reg <= fssr_pkg::ST_IDLE; // RULE_02
		end else begin
			case (state_reg)
				fssr_pkg::ST_IDLE: begin
					op_cnt_reg <= 9'h000;
					op_page_reg <= page_sel[1:0];
					op_off_reg <= addr_reg[7:0];
					op_len_reg <= data_cnt_reg;
					if (erase_start) begin
						state_reg <= fssr_pkg::ST_ERASE; // RULE_08
					end else if (prog_start) begin
						state_reg <= fssr_pkg::ST_PROG_RD; // RULE_22
					end
				end
				fssr_pkg::ST_ERASE: begin
					op_cnt_reg <= op_cnt_reg + 9'h001;
					if (op_cnt_reg[7:0] == 8'hFF) begin
						state_reg <= fssr_pkg::ST_SETTLE;
						settle_cnt_reg <= 16'(SETTLE_CYCLES - 1);
					end
				end
				fssr_pkg::ST_PROG_RD: begin
					state_reg <= fssr_pkg::ST_PROG_WR;
				end
				fssr_pkg::ST_PROG_WR: begin
					op_cnt_reg <= op_cnt_reg + 9'h001;
					if (op_cnt_reg + 9'h001 == op_len_reg) begin
						state_reg <= fssr_pkg::ST_SETTLE;
						settle_cnt_reg <= 16'(SETTLE_CYCLES - 1);
					end else begin
						state_reg <= fssr_pkg::ST_PROG_RD;
					end
				end
				fssr_pkg::ST_SETTLE: begin
					if (settle_done) begin
						state_reg <= fssr_pkg::ST_IDLE; // RULE_11 RULE_23
					end else begin
						settle_cnt_reg <= settle_cnt_reg - 16'h0001;
					end
				end
				default: begin
					state_reg <= fssr_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// ************************************************************
	// Memories
	// ************************************************************
	logic arr_wr_en;
	logic [9:0] arr_wr_addr;
	logic [7:0] arr_wr_data;
	logic [7:0] buf_rd_data;
	logic [7:0] prog_byte_addr;

	assign prog_byte_addr = op_off_reg + op_cnt_reg[7:0];
	assign arr_wr_en = state_reg == fssr_pkg::ST_ERASE || state_reg == fssr_pkg::ST_PROG_WR;
	assign arr_wr_addr = state_reg == fssr_pkg::ST_ERASE ? {op_page_reg, op_cnt_reg[7:0]}
		: {op_page_reg, prog_byte_addr};
	assign arr_wr_data = state_reg == fssr_pkg::ST_ERASE ? fssr_pkg::ERASED_BYTE : buf_rd_data;

	fssr_ram #(
		.WIDTH(8),
		.AW(fssr_pkg::ARRAY_AW)
	) u_array (
		.wr_clk(clk),
		.wr_en(arr_wr_en),
		.wr_addr(arr_wr_addr),
		.wr_data(arr_wr_data),
		.rd_clk(sclk),
		.rd_addr(read_ptr_reg),
		.rd_data(arr_rd_data)
	);

	fssr_ram #(
		.WIDTH(8),
		.AW(fssr_pkg::PAGE_AW)
	) u_page_buffer (
		.wr_clk(sclk),
		.wr_en(buf_wr_en),
		.wr_addr(addr_reg[7:0] + data_cnt_reg[7:0]),
		.wr_data(shift_next[7:0]),
		.rd_clk(clk),
		.rd_addr(prog_byte_addr),
		.rd_data(buf_rd_data)
	);

	// ************************************************************
	// Status outputs
	// ************************************************************
	assign ready_busy_flag = op_busy | reset_busy; // RULE_11
	assign page1_lock_bit = lock_reg[0];
	assign page2_lock_bit = lock_reg[1];
	assign page3_lock_bit = lock_reg[2];

	always_comb begin
		status_byte1 = 8'h00;
		status_byte1[fssr_pkg::STATUS_WEL_BIT] = write_enable_latch; // RULE_21
		status_byte1[fssr_pkg::STATUS_BUSY_BIT] = ready_busy_flag;
	end
endmodule
`default_nettype wire

// ### bench/fssr_core_monitor.sv
// Concurrent checks on the ports of fssr_core.
// Assumes it is bound into fssr_core and watches its clk domain.
`timescale 1ns/10ps
`default_nettype none
module fssr_core_monitor #(
	parameter int SETTLE_CYCLES = 1000
) (
	// System
	input wire logic clk,
	input wire logic reset,
	// Pins
	input wire logic cs_n,
	input wire logic so_oe,
	input wire logic wp_n,
	input wire logic lock_write_strobe,
	input wire logic [2:0] lock_write_value,
	// Status
	input wire logic write_enable_latch,
	input wire logic ready_busy_flag,
	input wire logic erase_suspended_flag,
	input wire logic program_suspended_flag,
	input wire logic page1_lock_bit,
	input wire logic page2_lock_bit,
	input wire logic page3_lock_bit,
	input wire logic [7:0] status_byte1,
	input wire logic [7:0] continuous_read_mode_byte,
	input wire logic [2:0] wrap_length_bits
);
	localparam int BUSY_MAX = 3100 + SETTLE_CYCLES;
	logic [2:0] locks;
	logic [12:0] busy_cnt_reg;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	assign locks = {page3_lock_bit, page2_lock_bit, page1_lock_bit};
	// Length of the current busy stretch
	always_ff @(posedge clk or posedge reset) begin
		if (reset)
			busy_cnt_reg <= 13'h0;
		else
			busy_cnt_reg <= ready_busy_flag ? busy_cnt_reg + 13'h1 : 13'h0;
	end
	sequence wp_low_s;
		(!wp_n)[*4];
	endsequence
	sequence lock_req_s;
		wp_n[*4] ##0 lock_write_strobe;
	endsequence
	status_map_a:
		assert property (status_byte1 == {6'h0, write_enable_latch, ready_busy_flag})
		else $error("status byte wrong");
	lock_frozen_a:
		assert property (wp_low_s |=> $stable(locks))
		else $error("lock bits moved with wp low");
	lock_set_a:
		assert property (lock_req_s |=> (locks & $past(lock_write_value)) == $past(lock_write_value))
		else $error("lock bits not set");
	lock_sticky_a:
		assert property (!($fell(page1_lock_bit) || $fell(page2_lock_bit) || $fell(page3_lock_bit)))
		else $error("lock bit cleared");
	latch_at_cs_a:
		assert property ($rose(write_enable_latch) |-> $past(cs_n, 2))
		else $error("latch set inside frame");
	busy_at_cs_a:
		assert property ($rose(ready_busy_flag) |-> $past(cs_n, 2))
		else $error("busy started inside frame");
	done_clears_a:
		assert property ($fell(ready_busy_flag) |-> !write_enable_latch)
		else $error("latch left set at done");
	so_released_a:
		assert property (cs_n |-> !so_oe)
		else $error("output driven while deselected");
	soft_clear_a:
		assert property ($rose(ready_busy_flag) && !write_enable_latch |-> ##[0:1]
			(continuous_read_mode_byte == 8'h0 && wrap_length_bits == 3'h0
			&& !erase_suspended_flag && !program_suspended_flag))
		else $error("volatile state kept by reset");
	busy_bound_a:
		assert property (busy_cnt_reg <= BUSY_MAX)
		else $error("busy too long");
endmodule
bind fssr_core fssr_core_monitor #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_fssr_core_monitor (
	.clk, .reset, .cs_n, .so_oe, .wp_n, .lock_write_strobe, .lock_write_value,
	.write_enable_latch, .ready_busy_flag, .erase_suspended_flag, .program_suspended_flag,
	.page1_lock_bit, .page2_lock_bit, .page3_lock_bit, .status_byte1,
	.continuous_read_mode_byte, .wrap_length_bits);
`default_nettype wire

// ### bench/fssr_host.sv
// Host serial controller model: one frame per call, MSB first.
// Assumes the bench leaves cs_n high between calls long enough.
`timescale 1ns/10ps
`default_nettype none
module fssr_host (
	// Serial link
	output logic sclk,
	output logic cs_n,
	output logic si,
	input wire logic so_out,
	input wire logic so_oe
);
	logic [63:0] rx;
	event got;
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si = 1'b1;
	end
	// Clock stands still outside the frame
	task automatic xfer(input logic [63:0] tx, input int n);
		rx = 64'h0;
		cs_n = 1'b0;
		for (int i = 0; i < n; i++) begin
			si = (i < 64) ? tx[63 - i] : 1'b0;
			#62.5 sclk = 1'b1;
			if (i >= 40)
				rx = {rx[62:0], so_oe ? so_out : 1'b1};
			#62.5 sclk = 1'b0;
		end
		#30 cs_n = 1'b1;
		si = ~si;
		if (n > 40)
			-> got;
	endtask
endmodule
`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the security-page, unique-ID and soft-reset core.
// Assumes fssr_host as link partner and the bound port checker.
`timescale 1ns/10ps
`default_nettype none
module testbench;
	localparam logic [63:0] UID = 64'h5A3C_96E1_0F2D_B487; // Arbitrary value
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic sclk, cs_n, si, so_out, so_oe;
	logic wp_n = 1'b1;
	logic lock_write_strobe = 1'b0;
	logic [2:0] lock_write_value = 3'h0;
	logic erase_suspend_set = 1'b0;
	logic program_suspend_set = 1'b0;
	logic suspend_clear = 1'b0;
	logic mode_load = 1'b0;
	logic [7:0] mode_value = 8'h0;
	logic [2:0] wrap_value = 3'h0;
	logic write_enable_latch, ready_busy_flag, erase_suspended_flag, program_suspended_flag;
	logic page1_lock_bit, page2_lock_bit, page3_lock_bit;
	logic [7:0] status_byte1, continuous_read_mode_byte;
	logic [2:0] wrap_length_bits;
	logic [63:0] exp_q[$];
	logic [31:0] r = 32'he30b;
	logic [15:0] d;
	int mismatches = 0;
	int n_compared = 0;
	always #5 clk = ~clk;
	fssr_core #(.UID_VALUE(UID), .SETTLE_CYCLES(10)) u_fssr_core (.clk, .reset, .sclk,
		.cs_n, .si, .so_out, .so_oe, .wp_n, .lock_write_strobe, .lock_write_value,
		.erase_suspend_set, .program_suspend_set, .suspend_clear, .mode_load, .mode_value,
		.wrap_value, .write_enable_latch, .ready_busy_flag, .erase_suspended_flag,
		.program_suspended_flag, .page1_lock_bit, .page2_lock_bit, .page3_lock_bit,
		.status_byte1, .continuous_read_mode_byte, .wrap_length_bits);
	fssr_host u_fssr_host (.sclk, .cs_n, .si, .so_out, .so_oe);
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic frame(input logic [63:0] v, input int nh, input int nd);
		u_fssr_host.xfer(v << (64 - nh), nh + nd);
		tick(6);
	endtask
	task automatic rd(input logic [63:0] v, input int nh, input int nd, input logic [63:0] e);
		exp_q.push_back(e);
		frame(v, nh, nd);
	endtask
	task automatic st(input string nm, input logic [1:0] e);
		check(nm, status_byte1, {6'h0, e});
	endtask
	task automatic wait_ready();
		int k;
		for (k = 0; k < 4000 && ready_busy_flag !== 1'b0; k++)
			tick(1);
		if (k == 4000)
			mismatches++;
	endtask
	task automatic lock(input logic [2:0] v);
		lock_write_value = v;
		lock_write_strobe = 1'b1;
		tick(1);
		lock_write_strobe = 1'b0;
		tick(2);
	endtask
	// Read data compared as each read frame closes
	always @(u_fssr_host.got)
		if (exp_q.size() > 0)
			check("so_data", u_fssr_host.rx, exp_q.pop_front());
	initial begin
		#900000;
		mismatches++;
		summarize();
	end
	initial begin
		tick(16);
		reset = 1'b0;
		tick(4);
		frame(64'h06, 8, 0);
		st("we", 2'b10);
		frame(64'h04, 8, 0);
		frame(64'h060, 12, 0);
		st("we_odd", 2'b00);
		frame(64'h06, 8, 0);
		frame(64'h4400_10A5, 32, 0);
		st("erase", 2'b11);
		wait_ready();
		st("erase_end", 2'b00);
		r = lfsr(r);
		d = r[15:0];
		frame(64'h06, 8, 0);
		frame({32'h4200_10FE, d}, 48, 0);
		st("prog", 2'b11);
		wait_ready();
		st("prog_end", 2'b00);
		rd(40'h48_0010_FE00, 40, 16, {48'h0, d});
		rd(40'h48_0010_0000, 40, 16, 64'hFFFF);
		rd(40'h48_0010_0000, 40, 4, 64'hF);
		check("oe", so_oe, 1'b0);
		rd(40'h4B_0000_0000, 40, 64, UID);
		frame(64'h06, 8, 0);
		frame(64'h4200_1000, 32, 0);
		st("prog_nodata", 2'b00);
		frame(64'h06, 8, 0);
		frame(64'h4400_1000, 32, 1);
		st("erase_abort", 2'b00);
		frame(64'h4400_1000, 32, 0);
		st("erase_nowel", 2'b00);
		frame(64'h06, 8, 0);
		frame(64'h4400_0000, 32, 0);
		st("erase_page0", 2'b00);
		wp_n = 1'b0;
		tick(4);
		lock(3'b010);
		check("lock_wp", {page3_lock_bit, page2_lock_bit, page1_lock_bit}, 3'b000);
		wp_n = 1'b1;
		tick(4);
		lock(3'b010);
		check("lock", {page3_lock_bit, page2_lock_bit, page1_lock_bit}, 3'b010);
		frame(64'h06, 8, 0);
		frame(64'h4400_2000, 32, 0);
		st("erase_locked", 2'b00);
		frame(64'h06, 8, 0);
		frame(64'h66, 8, 0);
		frame(64'h06, 8, 0);
		frame(64'h99, 8, 0);
		st("no_reset", 2'b10);
		r = lfsr(r);
		mode_value = r[7:0] | 8'h01;
		wrap_value = r[10:8] | 3'h1;
		{mode_load, erase_suspend_set, program_suspend_set, suspend_clear} = 4'hF;
		tick(1);
		{mode_load, erase_suspend_set, program_suspend_set, suspend_clear} = 4'h0;
		tick(2);
		check("preset", {erase_suspended_flag, program_suspended_flag, continuous_read_mode_byte,
			wrap_length_bits}, {2'b11, mode_value, wrap_value});
		wait_ready();
		frame(64'h66, 8, 0);
		frame(64'h99, 8, 0);
		st("reset", 2'b01);
		check("volatile", {continuous_read_mode_byte, wrap_length_bits, erase_suspended_flag,
			program_suspended_flag}, 13'h0);
		frame(64'h06, 8, 0);
		wait_ready();
		st("reset_end", 2'b00);
		frame(64'h06, 8, 0);
		st("after", 2'b10);
		summarize();
	end
endmodule
`default_nettype wire
